// *** design/sram_ctl.sv ***
// Host controller driving a four-die asynchronous 32-bit static memory.
// Assumes memory pins are sampled as synchronous to sys_clk; data pins split in/out/enable.
`timescale 1ns/1ps
`include "sram_ctl_cfg.svh"
// Overview of operation
// - Leave a gap between releasing one die select and asserting another.
// - Write strobe low at least 7 ns; whole write cycle at least 15 ns.
// - Select, enable and lanes active 10 ns before write strobe rises.
// - Write data valid 6 ns before strobe rise; removed after the edge.
// - Address valid from write start, 12 ns before end, stable throughout.
// - Write strobe high at least 5 ns between writes.
// - Byte-lane ended writes not used; lanes stay low across strobe.
// - Die select held low for the whole write strobe pulse.
// - At most one die select low at any time.
// - Write happens only with strobe, lane, select low and enable high.
// - Read with select, lane low, enable and strobe high; output enable gates drive.
module sram_ctl (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic io_33v, // I/O supply is 3.3V
  input wire logic io_known, // Supply choice is known
  input sram_ctl_pkg::mem_req_t req, // Request from user
  output logic req_ready, // Request accepted this cycle
  output logic rd_valid, // Read data strobe
  output logic [31:0] rd_data, // Read data
  output sram_ctl_pkg::mem_pins_t pins, // Memory pin outputs
  input wire logic [31:0] dq_in // Memory data pins in
);
  import sram_ctl_pkg::*;

  typedef struct packed {
    ctl_state_t state;
    mem_pins_t pins;
    logic ready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] last_die;
    logic [3:0] hold_cnt;
  } ctl_regs_t;

  ctl_regs_t st_r;
  ctl_regs_t st_nxt;
  logic tmr_load;
  logic [3:0] tmr_count;
  logic tmr_done;
  logic use_33;
  logic [3:0] rd_wait;
  logic [31:0] lane_mask;

  // ==========================================================
  // Supply selection
  // slower set default
  assign use_33 = io_known && io_33v;
  assign rd_wait = use_33 ? 4'(`RD_WAIT_33) : 4'(`RD_WAIT_25);

  // ==========================================================
  // Lane mask
  // lane to bit mapping
  genvar g;
  generate
    for (g = 0; g < `LANES; g++) begin : g_lane
      assign lane_mask[g*`LANE_W +: `LANE_W] = {`LANE_W{~st_r.pins.byte_lane_en_n[g]}};
    end
  endgenerate

  wait_timer #(.W(4)) u_timer (
    .sys_clk(sys_clk),
    .reset(reset),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // ==========================================================
  // Sequencer
  always_comb begin
    st_nxt = st_r;
    tmr_load = 1'b0;
    tmr_count = '0;
    st_nxt.ready = 1'b0;
    st_nxt.rvalid = 1'b0;
    case (st_r.state)
      ST_IDLE: begin
        if (req.valid && tmr_done && !st_r.ready) begin
          st_nxt.ready = 1'b1;
          st_nxt.last_die = req.addr[20:19];
          st_nxt.pins.addr = req.addr[18:0];
          st_nxt.pins.die_select_n = ~(4'h1 << req.addr[20:19]);
          st_nxt.pins.chip_en = 1'b1;
          st_nxt.pins.byte_lane_en_n = ~req.lane_en;
          tmr_load = 1'b1;
          if (req.write) begin
            st_nxt.pins.output_drive_en_n = 1'b1;
            st_nxt.pins.write_strobe_n = 1'b0;
            st_nxt.pins.dq_out = req.wdata;
            st_nxt.pins.dq_oe = 32'h0;
            st_nxt.hold_cnt = 4'(`OE_WAIT);
            tmr_count = 4'(`WR_SETUP);
            st_nxt.state = ST_WR_PULSE;
          end else begin
            st_nxt.pins.output_drive_en_n = 1'b0;
            st_nxt.pins.dq_oe = 32'h0;
            tmr_count = rd_wait;
            st_nxt.state = ST_RD_WAIT;
          end
        end
      end
      ST_RD_WAIT: begin
        if (tmr_done) begin
          st_nxt.rvalid = 1'b1;
          st_nxt.rdata = dq_in;
          st_nxt.pins.die_select_n = 4'hf;
          st_nxt.pins.chip_en = 1'b0;
          st_nxt.pins.output_drive_en_n = 1'b1;
          st_nxt.pins.byte_lane_en_n = 4'hf;
          tmr_load = 1'b1;
          tmr_count = 4'(`FLOAT_WAIT);
          st_nxt.state = ST_RD_FLOAT;
        end
      end
      ST_RD_FLOAT: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = 4'(`GAP_WAIT);
          st_nxt.state = ST_GAP;
        end
      end
      ST_WR_PULSE: begin
        if (st_r.hold_cnt != 4'h0) begin
          st_nxt.hold_cnt = st_r.hold_cnt - 4'h1;
        end else begin
          st_nxt.pins.dq_oe = lane_mask;
        end
        if (tmr_done && st_r.hold_cnt == 4'h0) begin
          st_nxt.pins.write_strobe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_count = 4'(`WR_HIGH);
          st_nxt.state = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        st_nxt.pins.dq_oe = 32'h0;
        st_nxt.pins.die_select_n = 4'hf;
        st_nxt.pins.chip_en = 1'b0;
        st_nxt.pins.byte_lane_en_n = 4'hf;
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = 4'(`GAP_WAIT);
          st_nxt.state = ST_GAP;
        end
      end
      ST_GAP: begin
        if (tmr_done) begin
          st_nxt.state = ST_IDLE;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r.state <= ST_IDLE;
      st_r.pins.die_select_n <= 4'hf;
      st_r.pins.chip_en <= 1'b0;
      st_r.pins.write_strobe_n <= 1'b1;
      st_r.pins.byte_lane_en_n <= 4'hf;
      st_r.pins.output_drive_en_n <= 1'b1;
      st_r.pins.addr <= 19'h0;
      st_r.pins.dq_out <= 32'h0;
      st_r.pins.dq_oe <= 32'h0;
      st_r.ready <= 1'b0;
      st_r.rvalid <= 1'b0;
      st_r.rdata <= 32'h0;
      st_r.last_die <= 2'h0;
      st_r.hold_cnt <= 4'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins = st_r.pins;
  assign req_ready = st_r.ready;
  assign rd_valid = st_r.rvalid;
  assign rd_data = st_r.rdata;

  // ==========================================================
  // Checks
  logic [3:0] low_cnt;
  always_ff @(posedge sys_clk) begin
    if (reset || st_r.pins.write_strobe_n) begin
      low_cnt <= 4'h0;
    end else if (low_cnt != 4'hf) begin
      low_cnt <= low_cnt + 4'h1;
    end
  end

  a_one_die_sel: assert property (@(posedge sys_clk) disable iff (reset)
    $countones(~st_r.pins.die_select_n) <= 1) else $error("More than one die selected");
  a_strobe_low_min: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(st_r.pins.write_strobe_n) |-> low_cnt >= 4'(`CYC_MIN(`WRITE_PULSE_MIN_PS)))
    else $error("Write strobe pulse too short");
  a_addr_setup_wr: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(st_r.pins.write_strobe_n) |-> low_cnt >= 4'(`WR_SETUP)) else $error("Address setup too short");
  a_sel_during_wr: assert property (@(posedge sys_clk) disable iff (reset)
    !st_r.pins.write_strobe_n |-> (st_r.pins.die_select_n != 4'hf && st_r.pins.chip_en))
    else $error("Die deselected during write");
  a_oe_off_write: assert property (@(posedge sys_clk) disable iff (reset)
    !st_r.pins.write_strobe_n |-> st_r.pins.output_drive_en_n) else $error("Output drive on in write");
  a_no_early_drive: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(st_r.pins.write_strobe_n) |-> st_r.pins.dq_oe == 32'h0 ##1 st_r.pins.dq_oe == 32'h0)
    else $error("Data driven before memory floats");
  a_strobe_high_min: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(st_r.pins.write_strobe_n) |-> st_r.pins.write_strobe_n [*2]) else $error("Strobe high too short");
  a_drive_under_wr: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.pins.dq_oe != 32'h0 |-> st_r.pins.output_drive_en_n &&
    (!st_r.pins.write_strobe_n || !$past(st_r.pins.write_strobe_n))) else $error("Data driven outside write");
  a_data_setup_wr: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(st_r.pins.write_strobe_n) |-> $past(st_r.pins.dq_oe) == $past(lane_mask))
    else $error("Write data not set up before strobe rise");
  a_die_tracked: assert property (@(posedge sys_clk) disable iff (reset)
    st_r.pins.die_select_n != 4'hf |-> !st_r.pins.die_select_n[st_r.last_die])
    else $error("Selected die differs from address");
  a_gap_sel: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(&st_r.pins.die_select_n) |-> (&st_r.pins.die_select_n) [*2]) else $error("Select gap too short");
  a_read_spacing: assert property (@(posedge sys_clk) disable iff (reset)
    (st_r.state == ST_IDLE && st_nxt.state == ST_RD_WAIT)
    |=> !st_r.rvalid [*5] ##1 st_r.rvalid) else $error("Read data sampled off the access window");
endmodule : sram_ctl

// *** design/sram_ctl_cfg.svh ***
// Timing and field constants for the static memory controller.
// Assumes a 125 MHz system clock; all counts derive from ps figures.
`ifndef SRAM_CTL_CFG_SVH
`define SRAM_CTL_CFG_SVH
`define CLK_PERIOD_PS 8000
`define CYC_MIN(ps) (((ps) + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Read timing, picoseconds, 2.5V and 3.3V columns
`define ADDR_ACCESS_TIME_25_PS 22000
`define ADDR_ACCESS_TIME_33_PS 20000
`define SEL_ACCESS_25_PS 22000
`define SEL_ACCESS_33_PS 21000
`define READ_CYCLE_MIN_25_PS 22000
`define READ_CYCLE_MIN_33_PS 20000
`define OE_ACCESS_25_PS 7500
`define OE_ACCESS_33_PS 6500
`define BE_ACCESS_25_PS 7000
`define BE_ACCESS_33_PS 6000
`define SEL_FLOAT_PS 4500
`define EN_FLOAT_PS 6000
`define OE_FLOAT_PS 4800
`define BE_FLOAT_PS 4300
`define SEL_GAP_PS 4500
// Write timing, picoseconds
`define WRITE_CYCLE_MIN_PS 15000
`define WRITE_PULSE_MIN_PS 7000
`define SEL_TO_WEND_PS 10000
`define DATA_TO_WEND_PS 6000
`define ADDR_TO_WEND_PS 12000
`define WRITE_FLOAT_PS 6000
`define WRITE_HIGH_MIN_PS 5000
// Derived cycle counts
`define RD_WAIT_25 (`CYC_MIN(`READ_CYCLE_MIN_25_PS) + 1)
`define RD_WAIT_33 (`CYC_MIN(`READ_CYCLE_MIN_33_PS) + 1)
`define OE_WAIT (`CYC_MIN(`WRITE_FLOAT_PS))
`define FLOAT_WAIT (`CYC_MIN(`EN_FLOAT_PS))
`define GAP_WAIT (`CYC_MIN(`SEL_GAP_PS))
`define WR_SETUP (`CYC_MIN(`ADDR_TO_WEND_PS))
`define WR_HIGH (`CYC_MIN(`WRITE_HIGH_MIN_PS))
`define WR_CYCLE (`CYC_MIN(`WRITE_CYCLE_MIN_PS))
`define LANE_W 8
`define LANES 4
`define DIES 4
`endif

// *** design/sram_ctl_pkg.sv ***
// Types for the static memory controller.
// Assumes the _cfg header is on the include path.
`include "sram_ctl_cfg.svh"
package sram_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD_WAIT = 3'b001,
    ST_RD_FLOAT = 3'b011,
    ST_GAP = 3'b010,
    ST_WR_PULSE = 3'b110,
    ST_WR_HIGH = 3'b111
  } ctl_state_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [20:0] addr;
    logic [31:0] wdata;
    logic [3:0] lane_en;
  } mem_req_t;
  typedef struct packed {
    logic [3:0] die_select_n;
    logic chip_en;
    logic write_strobe_n;
    logic [3:0] byte_lane_en_n;
    logic output_drive_en_n;
    logic [18:0] addr;
    logic [31:0] dq_out;
    logic [31:0] dq_oe;
  } mem_pins_t;
endpackage : sram_ctl_pkg

// *** design/wait_timer.sv ***
// Down counter that marks when a loaded wait has elapsed.
// Assumes a synchronous active-high reset.
`timescale 1ns/1ps
module wait_timer #(
  parameter int W = 4
) (
  input wire logic sys_clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic load, // Load a new wait
  input wire logic [W-1:0] count, // Cycles to wait
  output logic done // Wait elapsed
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } tmr_state_t;
  tmr_state_t st_r;
  tmr_state_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (load) begin
      st_nxt.cnt = count;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - 1'b1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // Registered compare only, so done never loops back through load
  assign done = (st_r.cnt == '0);
endmodule : wait_timer

// *** tb/sram_model.sv ***
// Behavioural four-die static memory facing the controller pins.
// Assumes controller pins change just after sys_clk rises.
`timescale 1ns/1ps
module sram_model (
  input wire logic sys_clk, // System clock
  input wire logic v33, // Device runs 3.3V I/O
  input sram_ctl_pkg::mem_pins_t pins, // Controller pins
  output logic [31:0] dq_in, // Data to controller
  output logic [31:0] drv // Bits driven by memory
);
  import sram_ctl_pkg::*;
  logic [31:0] mem [bit [20:0]];
  logic [31:0] junk_r = 32'h5a0f_c3a5;
  logic [28:0] seen_r = '0;
  logic [28:0] ctl;
  logic [31:0] lanes;
  logic [20:0] idx;
  logic sel;
  logic ok;
  int age_r = 0;
  int eff;
  // ==========================================
  // Read path
  always_comb begin
    ctl = {pins.die_select_n, pins.chip_en, pins.byte_lane_en_n, pins.output_drive_en_n, pins.addr};
    idx = {2'h0, pins.addr};
    for (int i = 0; i < 4; i++) begin
      if (!pins.die_select_n[i]) idx[20:19] = 2'(i);
    end
    sel = pins.die_select_n != 4'hf && pins.chip_en;
    for (int i = 0; i < 4; i++) lanes[8*i+:8] = {8{~pins.byte_lane_en_n[i]}};
    drv = (sel && pins.write_strobe_n && !pins.output_drive_en_n) ? lanes : 32'h0;
    // data valid only after access time
    eff = (ctl != seen_r) ? 0 : age_r;
    ok = (eff + 1) * 8 >= (v33 ? 21 : 22) && mem.exists(idx);
    dq_in = ok ? (mem[idx] & drv) | (junk_r & ~drv) : junk_r;
  end
  // ==========================================
  // Write path and timing state
  always @(posedge sys_clk) begin
    junk_r <= ~junk_r;
    seen_r <= ctl;
    age_r <= (ctl != seen_r) ? 1 : (age_r < 99 ? age_r + 1 : age_r);
    // lanes written under strobe, select and enable
    if (sel && !pins.write_strobe_n) begin
      for (int i = 0; i < 4; i++) begin
        if (!pins.byte_lane_en_n[i] && &pins.dq_oe[8*i+:8]) mem[idx][8*i+:8] = pins.dq_out[8*i+:8];
      end
    end
  end
endmodule : sram_model

// *** tb/tb.sv ***
// Testbench for the static memory controller against a behavioural memory.
// Assumes package, header and memory model are compiled first.
`timescale 1ns/1ps
`include "sram_ctl_cfg.svh"
module tb;
  import sram_ctl_pkg::*;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
  } note_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic io_33v = 1'b0;
  logic io_known = 1'b0;
  mem_req_t req = '0;
  logic req_ready;
  logic rd_valid;
  logic [31:0] rd_data;
  logic [31:0] dq_in;
  logic [31:0] drv;
  mem_pins_t pins;
  int errors = 0;
  int comparisons = 0;
  int lat = 0;
  note_t notes[$];
  logic [31:0] shadow [bit [20:0]];
  bit [20:0] addrs [4];
  logic [1:0] cfg [3] = '{2'b01, 2'b10, 2'b11};
  always #4 sys_clk = ~sys_clk;
  sram_ctl u_dut (.sys_clk(sys_clk), .reset(reset), .io_33v(io_33v), .io_known(io_known), .req(req),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .dq_in(dq_in));
  sram_model u_mem (.sys_clk(sys_clk), .v33(io_33v), .pins(pins), .dq_in(dq_in), .drv(drv));
  // ==========================================
  // Comparison and closing
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // ==========================================
  // Request driver, notes expected reads
  task automatic do_req(logic wr, bit [20:0] a, logic [31:0] d, logic [3:0] ln);
    int n;
    logic [31:0] m;
    m = {{8{ln[3]}}, {8{ln[2]}}, {8{ln[1]}}, {8{ln[0]}}};
    if (wr) shadow[a] = shadow.exists(a) ? (shadow[a] & ~m) | (d & m) : d;
    else notes.push_back('{data: shadow[a], mask: m});
    req = '{valid: 1'b1, write: wr, addr: a, wdata: d, lane_en: ln};
    n = 0;
    while (req_ready !== 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n == 40) check("ready wait", 32'h1, 32'h0);
    @(posedge sys_clk);
    #1;
  endtask : do_req
  // ==========================================
  // Output watcher
  always @(posedge sys_clk) begin
    note_t n;
    lat = (req_ready === 1'b1) ? 0 : lat + 1;
    if (!reset) begin
      check("die select", 32'h0, {28'h0, ~pins.die_select_n & (~pins.die_select_n - 4'h1)});
      check("strobe select", 32'h0, {31'h0, ~pins.write_strobe_n & (&pins.die_select_n)});
      check("contention", 32'h0, pins.dq_oe & drv);
      if (rd_valid === 1'b1) begin
        if (notes.size() == 0) check("read note", 32'h1, 32'h0);
        else begin
          n = notes.pop_front();
          check("read data", n.data & n.mask, rd_data & n.mask);
          check("read latency", (io_known & io_33v) ? `RD_WAIT_33 + 1 : `RD_WAIT_25 + 1, lat);
        end
      end
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(32'h65ff));
    repeat (10) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    check("reset pins", 32'h7bf, {21'h0, pins.die_select_n, pins.chip_en, pins.write_strobe_n,
      pins.byte_lane_en_n, pins.output_drive_en_n});
    foreach (cfg[c]) begin
      {io_known, io_33v} = cfg[c];
      for (int k = 0; k < 4; k++) begin
        addrs[k] = {2'(k), 19'($urandom)};
        do_req(1'b1, addrs[k], $urandom, 4'hf);
        do_req(1'b0, addrs[k], 32'h0, 4'hf);
      end
      for (int k = 0; k < 4; k++) begin
        do_req(1'b1, addrs[k], $urandom, 4'($urandom_range(1, 14)));
        do_req(1'b0, addrs[k], 32'h0, 4'($urandom_range(1, 15)));
      end
      foreach (addrs[k]) do_req(1'b0, addrs[k], 32'h0, 4'hf);
    end
    do_req(1'b1, {2'h3, 19'h7ffff}, 32'h0123abcd, 4'hf);
    req.valid = 1'b0;
    reset = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check("mid reset pins", 32'h7bf, {21'h0, pins.die_select_n, pins.chip_en, pins.write_strobe_n,
      pins.byte_lane_en_n, pins.output_drive_en_n});
    check("mid reset oe", 32'h0, pins.dq_oe);
    reset = 1'b0;
    do_req(1'b0, addrs[1], 32'h0, 4'hf);
    req.valid = 1'b0;
    repeat (20) @(posedge sys_clk);
    check("notes left", 32'h0, notes.size());
    wrap_up();
  end
  initial begin
    #100000;
    check("watchdog", 32'h1, 32'h0);
    wrap_up();
  end
endmodule : tb
